/* File: rtl/e1_frame_access_pkg.sv */
/*
 * Constants shared by the double-frame overhead access block: register
 * indices, field positions, reset values and line framing counts.
 * Assumes APB with 32-bit data; byte address is four times the index.
 */
package e1_frame_access_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // ************************************************************
    // register indices (byte address = index * 4)
    // ************************************************************
    localparam logic [9:0] IDX_TX_ALIGN = 10'h040;
    localparam logic [9:0] IDX_TX_NONALIGN = 10'h041;
    localparam logic [9:0] IDX_TX_INTL_ALIGN = 10'h042;
    localparam logic [9:0] IDX_TX_INTL_NONALIGN = 10'h043;
    localparam logic [9:0] IDX_TX_SPARE_CTRL = 10'h04A;
    localparam logic [9:0] IDX_RX_ALIGN = 10'h056;
    localparam logic [9:0] IDX_RX_NONALIGN = 10'h057;
    localparam logic [9:0] IDX_LINE_CTRL_1 = 10'h030;
    localparam logic [9:0] IDX_LINE_CTRL_4 = 10'h033;
    localparam logic [9:0] IDX_LINE_MODE = 10'h03F;
    localparam logic [9:0] IDX_STATUS_4 = 10'h01B;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] TX_ALIGN_RST = 8'h1B;
    localparam logic [7:0] TX_NONALIGN_RST = 8'h40;
    localparam logic [7:0] RX_FRAME_RST = 8'h00;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SR4_RX_ALIGN = 0;
    localparam int SR4_TX_ALIGN = 3;
    localparam int SR4_LOS = 7;
    localparam int SPARE_ALIGN_INTL = 7;
    localparam int SPARE_NONALIGN_INTL = 6;
    localparam int LC1_GAIN_LIMIT = 4;
    localparam int LC1_JA_TX_PATH = 3;
    localparam int LC1_JA_DEPTH = 2;
    localparam int LC1_JA_DISABLE = 1;
    localparam int MODE_SI_FROM_REG = 4;
    localparam int FRAME_INTL_BIT = 7;
    localparam int NONALIGN_ALARM_BIT = 5;

    // ************************************************************
    // framing counts, in line bits
    // ************************************************************
    localparam logic [8:0] DBL_FRAME_LAST = 9'd511;
    localparam logic [8:0] ALIGN_TS0_LAST = 9'd7;
    localparam logic [8:0] NONALIGN_TS0_FIRST = 9'd256;
    localparam logic [8:0] NONALIGN_TS0_LAST = 9'd263;
    localparam logic [8:0] NONALIGN_ALARM_POS = 9'd258;

    typedef enum logic [1:0] {
        MODE_T1 = 2'b00,
        MODE_E1 = 2'b01,
        MODE_J1 = 2'b10,
        MODE_6312K = 2'b11
    } line_mode_e;

endpackage

/* File: rtl/e1_double_frame_sa_si_access.sv */
/*
 * Double-frame overhead access: captures received align / non-align
 * timeslot-0 bits, inserts host-written overhead on transmit, and holds
 * the digital line interface controls. APB slave, zero wait states.
 * Assumes line clocks far slower than clock; line pins are asynchronous.
 */
// The APB slave port is this design's own decision.
// Contract
// - Receive overhead registers mirror received bits
// - Both receive registers update together at alignment
// - Receive flag sets on each register update
// - Transmit registers sampled when transmit flag sets
// - Unwritten transmit registers are retransmitted unchanged
// - Transmit registers hold contents until rewritten
// - Si source: register, per-frame registers, or passthrough
// - Receive align: Si bit 7, alignment bits 6..0
// - Non-align: Si, one, alarm, spare bits 4..0
// - Transmit non-align bit 5 is remote alarm
// - Transmit align: Si bit 7, pattern bits 6..0
// - Transmit and receive line modes set independently
// - 6312 kHz transmit only on clock output
// - Three bits select receive termination, zero external
// - Gain limit bit selects receive sensitivity range
// - Loss of signal switches receive clock source
// - Jitter attenuator only in T1 or E1
// - Align Si insertion control selects per-frame bits
module e1_double_frame_sa_si_access
    import e1_frame_access_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [e1_frame_access_pkg::ADDR_W-1:0] paddr,
    input wire logic [e1_frame_access_pkg::DATA_W-1:0] pwdata,
    output logic [e1_frame_access_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_line_clk,
    input wire logic rx_serial,
    input wire logic rx_frame_sync,
    input wire logic rx_loss_of_signal,
    input wire logic tx_line_clk,
    input wire logic tx_serial_in,
    output logic tx_line_data,
    output logic tx_line_en,
    output logic tx_clock_output,
    output logic rx_clock_from_mclk,
    output logic [2:0] rx_term_sel,
    output logic rx_gain_limit_sel,
    output logic jitter_atten_en,
    output logic jitter_atten_tx_path,
    output logic jitter_depth_128
);
    import e1_frame_access_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [2:0] rxc_sync;
        logic [1:0] rxd_sync;
        logic [1:0] rxs_sync;
        logic [1:0] los_sync;
        logic [2:0] txc_sync;
        logic [1:0] txd_sync;
        logic [8:0] rx_count;
        logic [7:0] rx_shift;
        logic [7:0] rx_af_hold;
        logic [7:0] rx_naf_hold;
        logic rx_hold_ok;
        logic [7:0] rx_align_frame_bits;
        logic [7:0] rx_nonalign_frame_bits;
        logic [8:0] tx_count;
        logic [2:0] dbl_index;
        logic [7:0] tx_af_shadow;
        logic [7:0] tx_naf_shadow;
        logic [7:0] tx_align_frame_bits;
        logic [7:0] tx_nonalign_frame_bits;
        logic [7:0] tx_intl_bit_align_regs;
        logic [7:0] tx_intl_bit_nonalign_regs;
        logic [7:0] tx_spare_insert_ctrl;
        logic [4:0] line_ctrl_1;
        logic [2:0] line_ctrl_4;
        logic [4:0] line_mode;
        logic rx_flag;
        logic tx_flag;
        logic tx_line;
        logic tx_clko;
        logic [31:0] rdata;
    } state_s;

    state_s s;
    state_s next_s;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
        reg_hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic e1_or_t1(input logic [1:0] m);
        e1_or_t1 = (m == MODE_T1) || (m == MODE_E1);
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        mapped = reg_hit(a, IDX_TX_ALIGN) || reg_hit(a, IDX_TX_NONALIGN)
            || reg_hit(a, IDX_TX_INTL_ALIGN) || reg_hit(a, IDX_TX_INTL_NONALIGN)
            || reg_hit(a, IDX_TX_SPARE_CTRL) || reg_hit(a, IDX_RX_ALIGN)
            || reg_hit(a, IDX_RX_NONALIGN) || reg_hit(a, IDX_LINE_CTRL_1)
            || reg_hit(a, IDX_LINE_CTRL_4) || reg_hit(a, IDX_LINE_MODE)
            || reg_hit(a, IDX_STATUS_4);
    endfunction

    function automatic state_s reset_state();
        reset_state = '0;
        reset_state.tx_align_frame_bits = TX_ALIGN_RST;
        reset_state.tx_nonalign_frame_bits = TX_NONALIGN_RST;
        reset_state.tx_af_shadow = TX_ALIGN_RST;
        reset_state.tx_naf_shadow = TX_NONALIGN_RST;
        reset_state.rx_align_frame_bits = RX_FRAME_RST;
        reset_state.rx_nonalign_frame_bits = RX_FRAME_RST;
    endfunction

    localparam state_s STATE_RST = reset_state();

    logic wr;
    logic rx_edge;
    logic tx_edge;
    logic [1:0] rx_mode;
    logic [1:0] tx_mode;
    logic [7:0] af_use;
    logic align_si;
    logic nonalign_si;
    logic tx_bit;
    logic [2:0] pos;
    logic rx_set;
    logic tx_set;
    logic [1:0] ja_mode;

    assign wr = psel && penable && pwrite;
    // edges are taken from the second and third stages only
    assign rx_edge = s.rxc_sync[1] && !s.rxc_sync[2];
    assign tx_edge = s.txc_sync[1] && !s.txc_sync[2];
    assign rx_mode = s.line_mode[1:0];
    assign tx_mode = s.line_mode[3:2];
    assign rx_set = rx_edge && s.rxs_sync[1] && s.rx_hold_ok;
    assign tx_set = tx_edge && (s.tx_count == 9'd0);
    // the attenuator follows the mode of the path it sits in
    assign ja_mode = s.line_ctrl_1[LC1_JA_TX_PATH] ? tx_mode : rx_mode;

    // ************************************************************
    // transmit bit selection
    // ************************************************************
    always_comb begin
        // a new double frame uses the register value sampled at its first bit
        af_use = (s.tx_count == 9'd0) ? s.tx_align_frame_bits : s.tx_af_shadow;
        if (s.tx_spare_insert_ctrl[SPARE_ALIGN_INTL]) begin
            align_si = s.tx_intl_bit_align_regs[3'd7 - s.dbl_index];
        end else if (s.line_mode[MODE_SI_FROM_REG]) begin
            align_si = af_use[FRAME_INTL_BIT];
        end else begin
            align_si = s.txd_sync[1];
        end
        if (s.tx_spare_insert_ctrl[SPARE_NONALIGN_INTL]) begin
            nonalign_si = s.tx_intl_bit_nonalign_regs[3'd7 - s.dbl_index];
        end else if (s.line_mode[MODE_SI_FROM_REG]) begin
            nonalign_si = s.tx_naf_shadow[FRAME_INTL_BIT];
        end else begin
            nonalign_si = s.txd_sync[1];
        end
        pos = s.tx_count[2:0];
        if (s.tx_count == 9'd0) begin
            tx_bit = align_si;
        end else if (s.tx_count <= ALIGN_TS0_LAST) begin
            tx_bit = af_use[3'd7 - pos];
        end else if (s.tx_count == NONALIGN_TS0_FIRST) begin
            tx_bit = nonalign_si;
        end else if (s.tx_count > NONALIGN_TS0_FIRST && s.tx_count <= NONALIGN_TS0_LAST) begin
            tx_bit = s.tx_naf_shadow[3'd7 - pos];
        end else begin
            tx_bit = s.txd_sync[1];
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.rxc_sync = {s.rxc_sync[1:0], rx_line_clk};
        next_s.rxd_sync = {s.rxd_sync[0], rx_serial};
        next_s.rxs_sync = {s.rxs_sync[0], rx_frame_sync};
        next_s.los_sync = {s.los_sync[0], rx_loss_of_signal};
        next_s.txc_sync = {s.txc_sync[1:0], tx_line_clk};
        next_s.txd_sync = {s.txd_sync[0], tx_serial_in};

        // receive: capture timeslot 0 of both frames, publish at align start
        if (rx_edge) begin
            next_s.rx_shift = {s.rx_shift[6:0], s.rxd_sync[1]};
            if (s.rxs_sync[1]) begin
                next_s.rx_count = 9'd1;
                if (s.rx_hold_ok) begin
                    next_s.rx_align_frame_bits = s.rx_af_hold;
                    next_s.rx_nonalign_frame_bits = s.rx_naf_hold;
                    next_s.rx_flag = 1'b1;
                end
                next_s.rx_hold_ok = 1'b0;
            end else begin
                next_s.rx_count = (s.rx_count == DBL_FRAME_LAST) ? 9'd0 : s.rx_count + 9'd1;
                if (s.rx_count == ALIGN_TS0_LAST) begin
                    next_s.rx_af_hold = {s.rx_shift[6:0], s.rxd_sync[1]};
                end
                if (s.rx_count == NONALIGN_TS0_LAST) begin
                    next_s.rx_naf_hold = {s.rx_shift[6:0], s.rxd_sync[1]};
                    next_s.rx_hold_ok = 1'b1;
                end
            end
        end

        // transmit: sample registers and raise flag at each double frame
        if (tx_edge) begin
            next_s.tx_count = (s.tx_count == DBL_FRAME_LAST) ? 9'd0 : s.tx_count + 9'd1;
            // in 6312 kHz mode the line pins stay quiet
            next_s.tx_line = (tx_mode != MODE_6312K) && tx_bit;
            next_s.tx_clko = (tx_mode == MODE_6312K) && tx_bit;
            if (s.tx_count == 9'd0) begin
                next_s.tx_af_shadow = s.tx_align_frame_bits;
                next_s.tx_naf_shadow = s.tx_nonalign_frame_bits;
                next_s.tx_flag = 1'b1;
                next_s.dbl_index = s.dbl_index + 3'd1;
            end
        end

        // apb: read data is registered in the setup cycle
        if (psel && !penable) begin
            next_s.rdata = '0;
            if (reg_hit(paddr, IDX_TX_ALIGN)) next_s.rdata[7:0] = s.tx_align_frame_bits;
            if (reg_hit(paddr, IDX_TX_NONALIGN)) next_s.rdata[7:0] = s.tx_nonalign_frame_bits;
            if (reg_hit(paddr, IDX_TX_INTL_ALIGN)) next_s.rdata[7:0] = s.tx_intl_bit_align_regs;
            if (reg_hit(paddr, IDX_TX_INTL_NONALIGN)) begin
                next_s.rdata[7:0] = s.tx_intl_bit_nonalign_regs;
            end
            if (reg_hit(paddr, IDX_TX_SPARE_CTRL)) next_s.rdata[7:0] = s.tx_spare_insert_ctrl;
            if (reg_hit(paddr, IDX_RX_ALIGN)) next_s.rdata[7:0] = s.rx_align_frame_bits;
            if (reg_hit(paddr, IDX_RX_NONALIGN)) next_s.rdata[7:0] = s.rx_nonalign_frame_bits;
            if (reg_hit(paddr, IDX_LINE_CTRL_1)) next_s.rdata[4:0] = s.line_ctrl_1;
            if (reg_hit(paddr, IDX_LINE_CTRL_4)) next_s.rdata[2:0] = s.line_ctrl_4;
            if (reg_hit(paddr, IDX_LINE_MODE)) next_s.rdata[4:0] = s.line_mode;
            if (reg_hit(paddr, IDX_STATUS_4)) begin
                next_s.rdata[SR4_RX_ALIGN] = s.rx_flag;
                next_s.rdata[SR4_TX_ALIGN] = s.tx_flag;
                next_s.rdata[SR4_LOS] = s.los_sync[1];
            end
        end
        if (wr) begin
            // held until rewritten, a single write serves fixed patterns
            if (reg_hit(paddr, IDX_TX_ALIGN)) next_s.tx_align_frame_bits = pwdata[7:0];
            if (reg_hit(paddr, IDX_TX_NONALIGN)) begin
                next_s.tx_nonalign_frame_bits = pwdata[7:0];
            end
            if (reg_hit(paddr, IDX_TX_INTL_ALIGN)) next_s.tx_intl_bit_align_regs = pwdata[7:0];
            if (reg_hit(paddr, IDX_TX_INTL_NONALIGN)) begin
                next_s.tx_intl_bit_nonalign_regs = pwdata[7:0];
            end
            if (reg_hit(paddr, IDX_TX_SPARE_CTRL)) next_s.tx_spare_insert_ctrl = pwdata[7:0];
            if (reg_hit(paddr, IDX_LINE_CTRL_1)) next_s.line_ctrl_1 = pwdata[4:0];
            if (reg_hit(paddr, IDX_LINE_CTRL_4)) next_s.line_ctrl_4 = pwdata[2:0];
            if (reg_hit(paddr, IDX_LINE_MODE)) next_s.line_mode = pwdata[4:0];
            // write-one acknowledge; a set in the same cycle wins
            if (reg_hit(paddr, IDX_STATUS_4)) begin
                if (pwdata[SR4_RX_ALIGN] && !rx_set) begin
                    next_s.rx_flag = 1'b0;
                end
                if (pwdata[SR4_TX_ALIGN] && !tx_set) begin
                    next_s.tx_flag = 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s <= STATE_RST;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // no wait state: read data was registered during the setup cycle
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = s.rdata;
    assign tx_line_data = s.tx_line;
    assign tx_line_en = (tx_mode != MODE_6312K);
    assign tx_clock_output = s.tx_clko;
    // no signal: receive clock falls back to the scaled master clock
    assign rx_clock_from_mclk = s.los_sync[1];
    assign rx_term_sel = s.line_ctrl_4;
    assign rx_gain_limit_sel = s.line_ctrl_1[LC1_GAIN_LIMIT];
    assign jitter_atten_en = !s.line_ctrl_1[LC1_JA_DISABLE] && e1_or_t1(ja_mode);
    assign jitter_atten_tx_path = s.line_ctrl_1[LC1_JA_TX_PATH];
    assign jitter_depth_128 = s.line_ctrl_1[LC1_JA_DEPTH];

    // ************************************************************
    // assertions
    // ************************************************************
    rx_capture_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        rx_set |=> (s.rx_align_frame_bits == $past(s.rx_af_hold))
            && (s.rx_nonalign_frame_bits == $past(s.rx_naf_hold)))
        else $error("receive overhead not loaded from captured bits");

    // a change away from the boundary could split a double frame
    rx_pair_update_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        ($changed(s.rx_align_frame_bits) || $changed(s.rx_nonalign_frame_bits))
            |-> $past(rx_set))
        else $error("receive overhead changed away from an align boundary");

    rx_flag_set_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        rx_set |=> s.rx_flag)
        else $error("receive align flag not set on update");

    tx_sample_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        tx_set |=> s.tx_flag && (s.tx_af_shadow == $past(s.tx_align_frame_bits))
            && (s.tx_naf_shadow == $past(s.tx_nonalign_frame_bits)))
        else $error("transmit registers not sampled with the flag");

    tx_hold_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !tx_set |=> $stable(s.tx_af_shadow) && $stable(s.tx_naf_shadow))
        else $error("transmit overhead changed inside a double frame");

    flag_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (wr && reg_hit(paddr, IDX_STATUS_4) && pwdata[SR4_RX_ALIGN] && !rx_set)
            |=> !s.rx_flag)
        else $error("receive align flag not cleared by acknowledge");

    tx_flag_clear_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (wr && reg_hit(paddr, IDX_STATUS_4) && pwdata[SR4_TX_ALIGN] && !tx_set)
            |=> !s.tx_flag)
        else $error("transmit align flag not cleared by acknowledge");

    tx_line_quiet_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (tx_edge && (tx_mode == MODE_6312K)) |=> !tx_line_data)
        else $error("line pins driven in 6312 kHz mode");

    ja_mode_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        !e1_or_t1(ja_mode) |-> !jitter_atten_en)
        else $error("jitter attenuator enabled outside T1 and E1");

    apb_ready_a: assert property (
        @(posedge clock) disable iff (!rst_n)
        (psel && penable) |-> pready)
        else $error("access phase without ready");

    // main scenarios reached
    rx_publish_c: cover property (@(posedge clock) disable iff (!rst_n) rx_set);
    tx_sample_c: cover property (@(posedge clock) disable iff (!rst_n) tx_set);
    flag_ack_c: cover property (@(posedge clock) disable iff (!rst_n)
        wr && reg_hit(paddr, IDX_STATUS_4) && pwdata[SR4_TX_ALIGN]);
    mode_6312_c: cover property (@(posedge clock) disable iff (!rst_n)
        tx_edge && (tx_mode == MODE_6312K));
endmodule

/* File: dv/e1_line_partner.sv */
/*
 * Far-end line model: sends a double-frame stream with chosen timeslot-0
 * bytes and watches the transmit stream for the expected overhead pair.
 * Assumes the framer samples line data on the rising line clock edge.
 */
module e1_line_partner (
    output logic line_clk,
    output logic rx_serial,
    output logic rx_frame_sync,
    input wire logic tx_line_data,
    input wire logic [7:0] rx_align,
    input wire logic [7:0] rx_nonalign,
    input wire logic [7:0] tx_align_exp,
    input wire logic [7:0] tx_nonalign_exp,
    input wire logic match_clear,
    output logic tx_match
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] pos;
    logic [511:0] hist;
    initial begin
        line_clk = 1'b0;
        rx_serial = 1'b0;
        rx_frame_sync = 1'b0;
        pos = 9'h000;
        hist = '0;
        tx_match = 1'b0;
    end
    // ************************************************************
    // line clock and receive stream
    // ************************************************************
    always #100 line_clk = ~line_clk;
    // drive on falling edge so data is settled at the rising edge
    always @(negedge line_clk) begin
        rx_frame_sync <= (pos == 9'h000);
        if (pos < 9'd8) begin
            rx_serial <= rx_align[3'd7 - pos[2:0]];
        end else if (pos >= 9'd256 && pos < 9'd264) begin
            rx_serial <= rx_nonalign[3'd7 - pos[2:0]];
        end else begin
            rx_serial <= pos[0] ^ pos[3];
        end
        pos <= pos + 9'd1;
        hist <= {hist[510:0], tx_line_data};
    end
    // ************************************************************
    // transmit overhead watch
    // ************************************************************
    // align and non-align bytes sit 256 bits apart; Si left out
    always @(posedge line_clk) begin
        if (match_clear) begin
            tx_match <= 1'b0;
        end else if (hist[262:256] == tx_align_exp[6:0] && hist[6:0] == tx_nonalign_exp[6:0]) begin
            tx_match <= 1'b1;
        end
    end
endmodule

/* File: dv/tb_top.sv */
/*
 * Self-checking bench for the double-frame overhead access block.
 * Assumes APB completes when pready is sampled high; line model beside it.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import e1_frame_access_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, line_clk, rx_serial, rx_frame_sync, tx_line_data;
    logic los = 1'b0, match_clear = 1'b0, tx_match, from_mclk;
    logic [7:0] rx_a = 8'h9B, rx_n = 8'h75, tx_a = TX_ALIGN_RST, tx_n = 8'h60;
    logic [2:0] term;
    logic gain, line_en, ja_en;
    int bad_count = 0, total_checks = 0;
    always #10 clock = ~clock;
    e1_double_frame_sa_si_access e1_double_frame_sa_si_access_i (.clock(clock),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_line_clk(line_clk), .rx_serial(rx_serial), .rx_frame_sync(rx_frame_sync),
        .rx_loss_of_signal(los), .tx_line_clk(line_clk), .tx_serial_in(1'b1),
        .tx_line_data(tx_line_data), .tx_line_en(line_en), .tx_clock_output(),
        .rx_clock_from_mclk(from_mclk), .rx_term_sel(term), .rx_gain_limit_sel(gain),
        .jitter_atten_en(ja_en), .jitter_atten_tx_path(), .jitter_depth_128());
    e1_line_partner e1_line_partner_i (.line_clk(line_clk), .rx_serial(rx_serial),
        .rx_frame_sync(rx_frame_sync), .tx_line_data(tx_line_data), .rx_align(rx_a),
        .rx_nonalign(rx_n), .tx_align_exp(tx_a), .tx_nonalign_exp(tx_n),
        .match_clear(match_clear), .tx_match(tx_match));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input bit wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) check(32'h0, 32'h1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // polls a status flag, then writes one to it in case it clears that way
    task automatic wait_flag(input int b);
        for (int i = 0; i < 6000; i++) begin
            apb(0, IDX_STATUS_4, 32'h0);
            if (rd[b] === 1'b1) break;
        end
        check({31'h0, rd[b]}, 32'h1);
        apb(1, IDX_STATUS_4, 32'h1 << b);
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic reset_values();
        apb(0, IDX_TX_ALIGN, 0); check(rd, 32'h1B);
        apb(0, IDX_TX_NONALIGN, 0); check(rd, 32'h40);
        apb(0, IDX_RX_ALIGN, 0); check(rd, 32'h00);
        apb(0, IDX_RX_NONALIGN, 0); check(rd, 32'h00);
    endtask
    task automatic rx_capture();
        wait_flag(SR4_RX_ALIGN);
        apb(0, IDX_RX_ALIGN, 0); check(rd, 32'h9B);
        apb(0, IDX_RX_NONALIGN, 0); check(rd, 32'h75);
        rx_a <= 8'h1B;
        rx_n <= 8'hC0;
        wait_flag(SR4_RX_ALIGN);
        wait_flag(SR4_RX_ALIGN);
        apb(0, IDX_RX_ALIGN, 0); check(rd, 32'h1B);
        apb(0, IDX_RX_NONALIGN, 0); check(rd, 32'hC0);
    endtask
    task automatic tx_insert();
        apb(1, IDX_TX_NONALIGN, 32'h60);
        wait_flag(SR4_TX_ALIGN);
        match_clear <= 1'b1;
        wait_flag(SR4_TX_ALIGN);
        match_clear <= 1'b0;
        wait_flag(SR4_TX_ALIGN);
        check({31'h0, tx_match}, 32'h1);
        apb(0, IDX_TX_NONALIGN, 0); check(rd, 32'h60);
    endtask
    task automatic line_ctrl();
        apb(1, IDX_LINE_CTRL_4, 32'h05);
        repeat (2) @(posedge clock);
        check({29'h0, term}, 32'h5);
        apb(1, IDX_LINE_CTRL_4, 32'h00);
        apb(1, IDX_LINE_CTRL_1, 32'h10);
        repeat (2) @(posedge clock);
        check({29'h0, term}, 32'h0);
        check({31'h0, gain}, 32'h1);
        los <= 1'b1;
        repeat (6) @(posedge clock);
        check({31'h0, from_mclk}, 32'h1);
        los <= 1'b0;
        repeat (6) @(posedge clock);
        check({31'h0, from_mclk}, 32'h0);
    endtask
    task automatic mode_ctrl();
        apb(1, IDX_LINE_MODE, 32'h0C);
        apb(0, IDX_LINE_MODE, 0); check(rd, 32'h0C);
        repeat (30) @(posedge clock);
        check({31'h0, line_en}, 32'h0);
        check({31'h0, tx_line_data}, 32'h0);
        check({31'h0, ja_en}, 32'h1);
        apb(1, IDX_LINE_CTRL_1, 32'h08);
        repeat (2) @(posedge clock);
        check({31'h0, ja_en}, 32'h0);
    endtask
    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        reset_values();
        rx_capture();
        tx_insert();
        line_ctrl();
        mode_ctrl();
        tally_and_finish();
    end
    initial begin
        #1200000;
        bad_count++;
        tally_and_finish();
    end
endmodule
